// ===== hsb_pkg.sv
/*
  Shared constants and carriers for the host status and bus configuration block.
  Assumes a single 200 MHz memory clock domain; offsets are byte addresses on the init port.
*/
package hsb_pkg;

  // Register byte offsets on the init port
  localparam logic [7:0]  STATUS_OFS    = 8'h00;
  localparam logic [7:0]  CFG_OFS       = 8'h04;

  // Configuration reset value and the bits that software may change
  localparam logic [31:0] CFG_RESET     = 32'h0180_0040;
  localparam logic [31:0] CFG_WR_MASK   = 32'h1fff_fb7c;

  localparam int          FIFO_DEPTH    = 32;
  localparam logic [4:0]  FREE_EMPTY    = 5'h1f;
  localparam logic [2:0]  SWAP_MAX      = 3'h7;
  localparam logic [2:0]  SWAP_ONE      = 3'h1;
  localparam logic [5:0]  RETRY_BASE    = 6'h08;
  localparam int          SYNC_STAGES   = 3;

  // Write flush timeout in memory clocks, by selector value
  localparam logic [8:0]  FLUSH_CLKS_0  = 9'h040;
  localparam logic [8:0]  FLUSH_CLKS_1  = 9'h080;
  localparam logic [8:0]  FLUSH_CLKS_2  = 9'h0c4;
  localparam logic [8:0]  FLUSH_CLKS_3  = 9'h100;

  typedef struct packed {
    logic        irq_flag;
    logic [2:0]  swaps_pending;
    logic [14:0] rsvd;
    logic        cmdq1_busy;
    logic        cmdq0_busy;
    logic        draw2d_busy;
    logic        chip_busy;
    logic        texture_busy;
    logic        pixel_busy;
    logic        vretrace_idle;
    logic        fifo_busy;
    logic [4:0]  fifo_free;
  } hsb_status_t;

  typedef struct packed {
    logic [2:0]  rsvd_hi;
    logic [1:0]  flush_sel;
    logic        fb_high_pri;
    logic [5:0]  lfb_threshold;
    logic        irq_tmo_en;
    logic        irq_en;
    logic [4:0]  retry_ext;
    logic        mem_retry_dis;
    logic        io_retry_dis;
    logic        rsvd10;
    logic        wr_wait;
    logic        rd_wait;
    logic        rsvd7;
    logic [4:0]  low_water;
    logic [1:0]  rsvd_lo;
  } hsb_cfg_t;

  typedef struct packed {
    logic pixel;
    logic tex_engine;
    logic tex_fifo;
    logic draw2d;
    logic cmdq0;
    logic cmdq1;
    logic other;
  } hsb_busy_t;

  localparam hsb_status_t STATUS_RESET = '{fifo_free: FREE_EMPTY, vretrace_idle: 1'b1, default: '0};

endpackage

// ===== hsb_flush_timer.sv
/*
  Write flush timer: pulses once each programmed period while host writes wait.
  Assumes pending is a same-clock level from the host write FIFO.
*/
`timescale 1ns/1ps
module hsb_flush_timer #(
  parameter int CNT_W = 9
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [1:0]       sel,
  input  wire logic             pending,
  output logic                  flush_ff
);

  if (CNT_W < 9) begin : g_chk
    $error("hsb_flush_timer: CNT_W too small for 256 clocks");
  end

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             nxt_flush;
  logic [8:0]       limit;

  always_comb begin
    unique case (sel)
      2'h0: limit = hsb_pkg::FLUSH_CLKS_0;
      2'h1: limit = hsb_pkg::FLUSH_CLKS_1;
      2'h2: limit = hsb_pkg::FLUSH_CLKS_2;
      2'h3: limit = hsb_pkg::FLUSH_CLKS_3;
    endcase
    nxt_cnt   = '0;
    nxt_flush = 1'b0;
    // Count restarts whenever the FIFO drains, so a flush never fires on empty
    if (pending) begin
      if (CNT_W'(limit) - CNT_W'(1) <= cnt_ff) begin
        nxt_flush = 1'b1; // [R20]
      end else begin
        nxt_cnt = cnt_ff + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff   <= '0;
      flush_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      flush_ff <= nxt_flush;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // A shorter timeout written mid-count flushes at once; that one cycle is exempt
  property p_flush_needs_wait;
    $rose(flush_ff) && $past(sel) == $past(sel, 2)
      |-> $past(pending) && $past(cnt_ff) == $past(CNT_W'(limit)) - CNT_W'(1);
  endproperty
  a_flush_needs_wait: assert property (p_flush_needs_wait) else $error("flush without full timeout"); // [R20]

  property p_count_bound;
    $stable(sel) |-> cnt_ff < CNT_W'(limit);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("flush counter past its limit"); // [R20]

endmodule

// ===== hsb_regs.sv
/*
  Host status and bus configuration registers of the graphics accelerator.
  Assumes a same-clock register port from the PCI target, engine busy levels on ref_clk,
  and an asynchronous vertical retrace level from video timing.
*/
// Functional notes
// R1: Low five status bits show free FIFO entries.
// R2: Status bit 5 is host FIFO busy.
// R3: Bit 6 low during vertical retrace.
// R4: Bit 7 shows pixel engine busy only.
// R5: Bit 8 set when texture unit not idle.
// R6: Bit 9 set while any unit active.
// R7: Bit 10 shows 2D engine busy.
// R8: Bits 11, 12 show command queue activity.
// R9: Pending swap count tracks issued minus completed.
// R10: Retrace interrupt sets bit 31, asserts line.
// R11: Status write clears interrupts, data ignored.
// R12: Config register read/write, resets 0x01800040.
// R13: Software keeps low-water mark nonzero, above 2.
// R14: Bits 8, 9 select read/write wait states.
// R15: Bits 11, 12 disable I/O, memory retries.
// R16: Retry interval field adds to 8 clocks.
// R17: Bits 18, 19 enable interrupt and timeout; bit 19 is only stored here, no timeout logic reads it.
// R18: Linear frame gathering threshold, reset 0x18.
// R19: Bit 26 raises frame buffer access priority.
// R20: Flush host writes after programmed timeout.
// R21: Reserved bits read zero, ignore writes.
`timescale 1ns/1ps
module hsb_regs #(
  parameter int FIFO_DEPTH = hsb_pkg::FIFO_DEPTH
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [31:0]         reg_wdata,
  output logic [31:0]              reg_rdata_ff,
  output logic                     reg_rvalid_ff,
  input  wire logic [4:0]          fifo_free,
  input  wire logic                fifo_busy,
  input  wire hsb_pkg::hsb_busy_t  busy_in,
  input  wire logic                vretrace_pin,
  input  wire logic                swap_issued,
  input  wire logic                swap_done,
  output logic                     int_pin_o_ff,
  output logic                     int_pin_oe_n_ff,
  output hsb_pkg::hsb_cfg_t        cfg_ff,
  output logic [5:0]               retry_clks_ff,
  output logic                     lfb_flush_ff
);

  if (FIFO_DEPTH != 32) begin : g_chk
    $error("hsb_regs: status field serves a 32-entry FIFO only");
  end

  hsb_pkg::hsb_status_t            status_ff;
  hsb_pkg::hsb_status_t            nxt_status;
  hsb_pkg::hsb_cfg_t               nxt_cfg;
  logic [hsb_pkg::SYNC_STAGES-1:0] sync_ff;
  logic [hsb_pkg::SYNC_STAGES-1:0] nxt_sync;
  logic                            retrace_ff;
  logic                            nxt_retrace;
  logic [31:0]                     nxt_rdata;
  logic                            nxt_rvalid;
  logic                            nxt_int_oe_n;
  logic [5:0]                      nxt_retry_clks;
  logic                            status_wr;
  logic                            cfg_wr;
  logic                            irq_set;
  logic                            fifo_pending;

  assign status_wr    = reg_wr && reg_addr == hsb_pkg::STATUS_OFS;
  assign cfg_wr       = reg_wr && reg_addr == hsb_pkg::CFG_OFS;
  assign fifo_pending = status_ff.fifo_free != hsb_pkg::FREE_EMPTY;

  // Event: retrace begins while interrupts are enabled
  assign irq_set      = nxt_retrace && !retrace_ff && cfg_ff.irq_en; // [R10] [R17]

  always_comb begin
    // Pin side: a change is taken only once stages two and three agree
    nxt_sync    = {sync_ff[hsb_pkg::SYNC_STAGES-2:0], vretrace_pin};
    nxt_retrace = retrace_ff;
    if (sync_ff[hsb_pkg::SYNC_STAGES-2] == sync_ff[hsb_pkg::SYNC_STAGES-1]) begin
      nxt_retrace = sync_ff[hsb_pkg::SYNC_STAGES-1]; // [R3]
    end

    nxt_status               = '0;
    nxt_status.fifo_free     = fifo_free; // [R1]
    nxt_status.fifo_busy     = fifo_busy; // [R2]
    nxt_status.vretrace_idle = !retrace_ff; // [R3]
    nxt_status.pixel_busy    = busy_in.pixel; // [R4]
    nxt_status.texture_busy  = busy_in.tex_engine | busy_in.tex_fifo; // [R5]
    nxt_status.draw2d_busy   = busy_in.draw2d; // [R7]
    nxt_status.cmdq0_busy    = busy_in.cmdq0; // [R8]
    nxt_status.cmdq1_busy    = busy_in.cmdq1; // [R8]
    nxt_status.chip_busy     = busy_in.pixel | busy_in.tex_engine | busy_in.tex_fifo
                             | busy_in.draw2d | busy_in.cmdq0 | busy_in.cmdq1
                             | busy_in.other | fifo_busy | (fifo_free != hsb_pkg::FREE_EMPTY); // [R6]

    // Counter saturates; issue and completion in one cycle cancel out
    nxt_status.swaps_pending = status_ff.swaps_pending;
    if (swap_issued && !swap_done && status_ff.swaps_pending != hsb_pkg::SWAP_MAX) begin
      nxt_status.swaps_pending = status_ff.swaps_pending + hsb_pkg::SWAP_ONE; // [R9]
    end else if (swap_done && !swap_issued && status_ff.swaps_pending != '0) begin
      nxt_status.swaps_pending = status_ff.swaps_pending - hsb_pkg::SWAP_ONE; // [R9]
    end

    // A new interrupt in the clearing cycle survives the clear
    nxt_status.irq_flag = irq_set | (status_ff.irq_flag & !status_wr); // [R10] [R11]
    nxt_int_oe_n        = !nxt_status.irq_flag; // [R10]

    nxt_cfg = cfg_ff;
    if (cfg_wr) begin
      nxt_cfg = (cfg_ff & ~hsb_pkg::CFG_WR_MASK) | (reg_wdata & hsb_pkg::CFG_WR_MASK); // [R12] [R21]
    end
    nxt_retry_clks = hsb_pkg::RETRY_BASE + {1'b0, nxt_cfg.retry_ext}; // [R16]

    nxt_rvalid = reg_rd;
    nxt_rdata  = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        hsb_pkg::STATUS_OFS: nxt_rdata = status_ff;
        hsb_pkg::CFG_OFS:    nxt_rdata = cfg_ff; // [R12]
        default:             nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_ff         <= '0;
      retrace_ff      <= 1'b0;
      status_ff       <= hsb_pkg::STATUS_RESET;
      cfg_ff          <= hsb_pkg::CFG_RESET; // [R12] [R18]
      retry_clks_ff   <= hsb_pkg::RETRY_BASE;
      int_pin_o_ff    <= 1'b0;
      int_pin_oe_n_ff <= 1'b1;
      reg_rdata_ff    <= '0;
      reg_rvalid_ff   <= 1'b0;
    end else begin
      sync_ff         <= nxt_sync;
      retrace_ff      <= nxt_retrace;
      status_ff       <= nxt_status;
      cfg_ff          <= nxt_cfg;
      retry_clks_ff   <= nxt_retry_clks;
      int_pin_o_ff    <= 1'b0;
      int_pin_oe_n_ff <= nxt_int_oe_n;
      reg_rdata_ff    <= nxt_rdata;
      reg_rvalid_ff   <= nxt_rvalid;
    end
  end

  // Wait states, retry disables, priority and threshold leave as cfg_ff fields
  // for the PCI target and memory arbiter. [R14] [R15] [R18] [R19]
  // The low-water mark is taken as written; keeping it sane is up to software. [R13]

  // Timer restarts each time the FIFO drains, trading latency for larger bursts
  hsb_flush_timer #(
    .CNT_W    (9)
  ) u_flush (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .sel      (cfg_ff.flush_sel),
    .pending  (fifo_pending),
    .flush_ff (lfb_flush_ff)
  ); // [R20]

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_retrace_high;
    vretrace_pin [*5];
  endsequence

  sequence s_retrace_low;
    !vretrace_pin [*5];
  endsequence

  sequence s_read(logic [7:0] ofs);
    reg_rd && reg_addr == ofs;
  endsequence

  property p_free_follows;
    ##1 status_ff.fifo_free == $past(fifo_free) && status_ff.fifo_busy == $past(fifo_busy);
  endproperty
  a_free_follows: assert property (p_free_follows) else $error("free count or busy stale"); // [R1]

  property p_retrace_active;
    s_retrace_high |=> !status_ff.vretrace_idle;
  endproperty
  a_retrace_active: assert property (p_retrace_active) else $error("retrace not shown active"); // [R3]

  property p_retrace_idle;
    s_retrace_low |=> status_ff.vretrace_idle;
  endproperty
  a_retrace_idle: assert property (p_retrace_idle) else $error("retrace not shown idle"); // [R3]

  property p_engines;
    ##1 status_ff.pixel_busy == $past(busy_in.pixel)
      && status_ff.texture_busy == $past(busy_in.tex_engine || busy_in.tex_fifo)
      && status_ff.draw2d_busy == $past(busy_in.draw2d)
      && status_ff.cmdq0_busy == $past(busy_in.cmdq0) && status_ff.cmdq1_busy == $past(busy_in.cmdq1);
  endproperty
  a_engines: assert property (p_engines) else $error("engine busy bit wrong"); // [R4]

  property p_chip_idle;
    status_ff.pixel_busy || status_ff.texture_busy || fifo_pending |-> status_ff.chip_busy;
  endproperty
  a_chip_idle: assert property (p_chip_idle) else $error("chip idle while a unit works"); // [R6]

  property p_swap_inc;
    swap_issued && !swap_done && status_ff.swaps_pending < hsb_pkg::SWAP_MAX
      |=> status_ff.swaps_pending == $past(status_ff.swaps_pending) + hsb_pkg::SWAP_ONE;
  endproperty
  a_swap_inc: assert property (p_swap_inc) else $error("swap count did not rise"); // [R9]

  property p_swap_dec;
    swap_done && !swap_issued && status_ff.swaps_pending != '0
      |=> status_ff.swaps_pending == $past(status_ff.swaps_pending) - hsb_pkg::SWAP_ONE;
  endproperty
  a_swap_dec: assert property (p_swap_dec) else $error("swap count did not fall"); // [R9]

  property p_irq_raise;
    irq_set |=> status_ff.irq_flag && !int_pin_oe_n_ff;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("retrace interrupt not raised"); // [R10]

  property p_irq_line;
    int_pin_oe_n_ff == !status_ff.irq_flag && !int_pin_o_ff;
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("interrupt line disagrees with flag"); // [R10]

  property p_irq_clear;
    status_wr && !irq_set |=> !status_ff.irq_flag ##0 int_pin_oe_n_ff;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status write left interrupt set"); // [R11]

  property p_cfg_write;
    cfg_wr |=> cfg_ff == (($past(reg_wdata) & hsb_pkg::CFG_WR_MASK) | (hsb_pkg::CFG_RESET & ~hsb_pkg::CFG_WR_MASK));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write mishandled"); // [R12] [R21]

  property p_cfg_read;
    s_read(hsb_pkg::CFG_OFS) and !cfg_wr |=> reg_rvalid_ff && reg_rdata_ff == cfg_ff;
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config read wrong"); // [R12]

  property p_retry;
    ##1 retry_clks_ff == hsb_pkg::RETRY_BASE + {1'b0, cfg_ff.retry_ext};
  endproperty
  a_retry: assert property (p_retry) else $error("retry interval not field plus 8"); // [R16]

  property p_irq_enable;
    !cfg_ff.irq_en && !status_ff.irq_flag |=> !status_ff.irq_flag;
  endproperty
  a_irq_enable: assert property (p_irq_enable) else $error("interrupt while disabled"); // [R17]

  // Set wins over a clear in the same cycle, so a retrace start is never lost
  property p_irq_set_wins;
    irq_set && status_wr |=> status_ff.irq_flag;
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins) else $error("clear beat a new interrupt"); // [R10] [R11]

  property p_irq_hold;
    status_ff.irq_flag && !status_wr |=> status_ff.irq_flag;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without a status write"); // [R10]

  property p_swap_hold;
    (swap_issued == swap_done) || (swap_issued && status_ff.swaps_pending == hsb_pkg::SWAP_MAX)
      || (swap_done && status_ff.swaps_pending == '0) |=> $stable(status_ff.swaps_pending);
  endproperty
  a_swap_hold: assert property (p_swap_hold) else $error("swap count moved while it should hold"); // [R9]

  property p_chip_idle_clear;
    !fifo_busy && fifo_free == hsb_pkg::FREE_EMPTY && busy_in == '0 |=> !status_ff.chip_busy;
  endproperty
  a_chip_idle_clear: assert property (p_chip_idle_clear) else $error("chip busy with every unit idle"); // [R6]

  // Register port: every read is answered next cycle, unmapped ones with zero
  property p_rvalid_pulse;
    ##1 reg_rvalid_ff == $past(reg_rd);
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer not one cycle after strobe"); // [R12]

  property p_status_read;
    s_read(hsb_pkg::STATUS_OFS) |=> reg_rvalid_ff && reg_rdata_ff == $past(status_ff);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong"); // [R1]

  property p_unmapped_read;
    reg_rd && reg_addr != hsb_pkg::STATUS_OFS && reg_addr != hsb_pkg::CFG_OFS |=> reg_rdata_ff == '0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // [R21]

  property p_cfg_hold;
    !cfg_wr |=> $stable(cfg_ff);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without a write"); // [R12]

  property p_rsvd_zero;
    status_ff.rsvd == '0 && (cfg_ff & ~hsb_pkg::CFG_WR_MASK) == '0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set"); // [R21]

endmodule

// ===== hsb_host_model.sv
/*
  Host model: issues full-word writes and reads on the strobed register port.
  Assumes the bench calls wr and rd hierarchically and that requests are taken on rising edges.
*/
`timescale 1ns/1ps
module hsb_host_model (
  input  wire logic        ref_clk,
  output logic [7:0]       reg_addr,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [31:0]      reg_wdata,
  input  wire logic [31:0] reg_rdata_ff,
  input  wire logic        reg_rvalid_ff
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0000_0000;
  end

  // Released lines flip, so a design that samples late cannot match by luck
  task automatic release_bus();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    release_bus();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    release_bus();
    // The answer stands one cycle only; a late or missing one reads as unknown
    d = (reg_rvalid_ff === 1'b1) ? reg_rdata_ff : 'x;
  endtask
endmodule

// ===== hsb_regs_tb_top.sv
/*
  Self-checking bench for the host status and bus configuration registers.
  Assumes hsb_host_model drives the register port; the bench drives all status inputs.
*/
`timescale 1ns/1ps
module hsb_regs_tb_top;
  localparam int         TMO = 20000;
  localparam logic [31:0] FLUSH_EXP [4] = '{32'h40, 32'h80, 32'hc4, 32'h100};
  logic                  ref_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [4:0]            fifo_free = 5'h1f;
  logic                  fifo_busy = 1'b0;
  hsb_pkg::hsb_busy_t    busy_in = '0;
  logic                  vretrace_pin = 1'b0;
  logic                  swap_issued = 1'b0;
  logic                  swap_done = 1'b0;
  logic [7:0]            reg_addr;
  logic                  reg_wr, reg_rd, reg_rvalid_ff, int_pin_o_ff, int_pin_oe_n_ff, lfb_flush_ff;
  logic [31:0]           reg_wdata, reg_rdata_ff;
  hsb_pkg::hsb_cfg_t     cfg_ff;
  logic [5:0]            retry_clks_ff;
  int                    bad_count = 0;
  int                    tests_run = 0;
  int                    cyc = 0;
  // Interrupt line has a pull-up; the device only pulls it low
  wire                   int_line = int_pin_oe_n_ff ? 1'b1 : int_pin_o_ff;
  // {fifo_free, fifo_busy, busy_in, expected status}
  logic [44:0]           rows [10] = '{
    {5'h1f, 1'b0, 7'h00, 32'h005f}, {5'h10, 1'b0, 7'h00, 32'h0250},
    {5'h1f, 1'b1, 7'h00, 32'h027f}, {5'h1f, 1'b0, 7'h40, 32'h02df},
    {5'h1f, 1'b0, 7'h20, 32'h035f}, {5'h1f, 1'b0, 7'h10, 32'h035f},
    {5'h1f, 1'b0, 7'h08, 32'h065f}, {5'h1f, 1'b0, 7'h04, 32'h0a5f},
    {5'h1f, 1'b0, 7'h02, 32'h125f}, {5'h1f, 1'b0, 7'h01, 32'h025f}};

  always #2.5 ref_clk = ~ref_clk;

  hsb_host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff));

  hsb_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
    .fifo_free(fifo_free), .fifo_busy(fifo_busy), .busy_in(busy_in), .vretrace_pin(vretrace_pin),
    .swap_issued(swap_issued), .swap_done(swap_done), .int_pin_o_ff(int_pin_o_ff),
    .int_pin_oe_n_ff(int_pin_oe_n_ff), .cfg_ff(cfg_ff), .retry_clks_ff(retry_clks_ff),
    .lfb_flush_ff(lfb_flush_ff));

  task automatic wrap_up();
    if (bad_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    host.rd(a, v);
    chk(v, exp);
  endtask

  task automatic swaps(input logic i, input logic dn, input int n);
    repeat (n) begin
      @(negedge ref_clk);
      swap_issued = i;
      swap_done = dn;
      @(negedge ref_clk);
      swap_issued = 1'b0;
      swap_done = 1'b0;
    end
  endtask

  // Distance in cycles between two flush pulses, bounded so a dead timer cannot hang
  task automatic flush_period(output int n);
    int k;
    for (k = 0; k < 600 && lfb_flush_ff !== 1'b1; k++) @(negedge ref_clk);
    @(negedge ref_clk);
    n = 1;
    for (k = 0; k < 600 && lfb_flush_ff !== 1'b1; k++) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == TMO) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    int i;
    int n;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    chk(cfg_ff, hsb_pkg::CFG_RESET);
    chk({26'h0, retry_clks_ff}, 32'h8);
    chk({31'h0, int_line}, 32'h1);
    rchk(8'h00, 32'h0000_005f);
    rchk(8'h04, 32'h0180_0040);
    for (i = 0; i < 10; i++) begin
      @(negedge ref_clk);
      {fifo_free, fifo_busy, busy_in} = rows[i][44:32];
      @(negedge ref_clk);
      rchk(8'h00, rows[i][31:0]);
    end
    {fifo_free, fifo_busy, busy_in} = {5'h1f, 1'b0, 7'h00};
    host.wr(8'h04, 32'hffff_ffff);
    @(negedge ref_clk);
    chk(cfg_ff, hsb_pkg::CFG_WR_MASK);
    chk({26'h0, retry_clks_ff}, 32'h27);
    rchk(8'h04, 32'h1fff_fb7c);
    // Low-water mark is written as 3 so the host keeps overflow checking alive
    host.wr(8'h04, 32'he000_048f);
    @(negedge ref_clk);
    chk({26'h0, retry_clks_ff}, 32'h8);
    rchk(8'h04, 32'h0000_000c);
    rchk(8'h08, 32'h0000_0000);
    host.wr(8'h04, 32'h0184_0040);
    vretrace_pin = 1'b1;
    // Clear lands in the cycle the synchronised retrace rises: the new interrupt must survive
    repeat (2) @(negedge ref_clk);
    host.wr(8'h00, 32'h0000_0000);
    repeat (8) @(negedge ref_clk);
    chk({31'h0, int_line}, 32'h0);
    rchk(8'h00, 32'h8000_001f);
    host.wr(8'h00, 32'hffff_ffff);
    @(negedge ref_clk);
    chk({31'h0, int_line}, 32'h1);
    rchk(8'h00, 32'h0000_001f);
    vretrace_pin = 1'b0;
    host.wr(8'h04, 32'h0180_0040);
    repeat (8) @(negedge ref_clk);
    vretrace_pin = 1'b1;
    repeat (8) @(negedge ref_clk);
    chk({31'h0, int_line}, 32'h1);
    rchk(8'h00, 32'h0000_001f);
    vretrace_pin = 1'b0;
    repeat (8) @(negedge ref_clk);
    swaps(1'b1, 1'b0, 3);
    rchk(8'h00, 32'h3000_005f);
    swaps(1'b1, 1'b1, 2);
    rchk(8'h00, 32'h3000_005f);
    swaps(1'b0, 1'b1, 1);
    rchk(8'h00, 32'h2000_005f);
    // Count saturates at both ends of its three bits
    swaps(1'b1, 1'b0, 6);
    rchk(8'h00, 32'h7000_005f);
    swaps(1'b0, 1'b1, 8);
    rchk(8'h00, 32'h0000_005f);
    fifo_free = 5'h10;
    for (i = 0; i < 4; i++) begin
      host.wr(8'h04, hsb_pkg::CFG_RESET | (32'(i) << 27));
      flush_period(n);
      chk(32'(n), FLUSH_EXP[i]);
    end
    // Reset in mid-run must drop the swap count and the written configuration
    fifo_free = 5'h1f;
    swaps(1'b1, 1'b0, 1);
    rst_n = 1'b0;
    @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    chk(cfg_ff, hsb_pkg::CFG_RESET);
    chk({26'h0, retry_clks_ff}, 32'h8);
    rchk(8'h00, 32'h0000_005f);
    wrap_up();
  end
endmodule
